// ===== core/control_word_bit_router_map.vh
// constants of the control word bit router: codes, field widths, reset values
// assumes inclusion by bare name from the router and its per-bit selector
`ifndef CONTROL_WORD_BIT_ROUTER_MAP_VH
`define CONTROL_WORD_BIT_ROUTER_MAP_VH

// number of internal function-input control bits
`define CWR_NUM_BITS 16
// number of terminal-side logic inputs (base, expansion, extended)
`define CWR_NUM_TERM 14
// first index of expansion card inputs and of extended card inputs
`define CWR_EXP_FIRST 6
`define CWR_EXT_FIRST 10

// configuration operation codes
`define CWR_OP_CLEAR 2'h0
`define CWR_OP_FIXED 2'h1
`define CWR_OP_SWITCHED 2'h2

// stored assignment kind of one bit
`define CWR_KIND_NONE 2'h0
`define CWR_KIND_FIXED 2'h1
`define CWR_KIND_SWITCHED 2'h2

// source channel codes
`define CWR_SRC_TERMINAL 3'h0
`define CWR_SRC_MODBUS 3'h1
`define CWR_SRC_CANOPEN 3'h2
`define CWR_SRC_NETCARD 3'h3
`define CWR_SRC_INTERNAL 3'h4

// run command modes
`define CWR_MODE_TWO_WIRE 1'h0
`define CWR_MODE_THREE_WIRE 1'h1

// reset values
`define CWR_RST_BITS 16'h0000
`define CWR_RST_KIND 2'h0
`define CWR_RST_SRC 3'h0
`define CWR_RST_SWITCH 4'h0

`endif

// ===== core/bit_source_select.v
// per-bit source selector: picks the value of one internal control bit
// assumes all inputs are synchronous to the drive clock; purely combinational
`timescale 1ns/1ps
`include "control_word_bit_router_map.vh"

module bit_source_select (
   input wire [1:0] kind,
   input wire [2:0] source,
   input wire switchLevel,
   input wire terminalBit,
   input wire terminalValid,
   input wire modbusBit,
   input wire canopenBit,
   input wire netcardBit,
   input wire internalBit,
   output reg value
);

   reg commBit;

   // same-position bit of the configured communication channel
   always @* begin
      commBit = 1'b0;
      case (source)
         `CWR_SRC_MODBUS: commBit = modbusBit;
         `CWR_SRC_CANOPEN: commBit = canopenBit;
         `CWR_SRC_NETCARD: commBit = netcardBit;
         `CWR_SRC_INTERNAL: commBit = internalBit;
         default: commBit = 1'b0;
      endcase
   end

   // fixed follows one source, switched lets the switch input choose
   always @* begin
      value = 1'b0;
      case (kind)
         `CWR_KIND_FIXED: begin
            if (source == `CWR_SRC_TERMINAL) begin
               value = terminalBit & terminalValid;
            end else begin
               value = commBit;
            end
         end
         `CWR_KIND_SWITCHED: begin
            if (switchLevel) begin
               value = commBit;
            end else begin
               value = terminalBit & terminalValid;
            end
         end
         default: value = 1'b0;
      endcase
   end

endmodule

// ===== core/control_word_bit_router.v
// control word bit router: drives the 16 internal function-input control bits
// from terminal inputs and four communication control words, with a per-bit
// assignment table written through a simple configuration strobe port
// assumes terminal inputs and control words are synchronous to clock
`timescale 1ns/1ps
`include "control_word_bit_router_map.vh"

// Functional notes
// - not-separate mode: reference switch selects command
// - each of 16 bits configured on its own
// - switched source uses same-position terminal and words
// - base inputs 1-6 feed bits 0-5
// - expansion inputs 7-10 feed bits 6-9
// - extended inputs 11-14 feed bits 10-13
// - refuse fixed on switched bit and vice versa
// - two-wire mode locks bit 0 as forward
// - three-wire locks bit 0 authorization, bit 1 forward
// - fixed code names channel and same bit position
// - switch input level picks terminal or word bit
// - separate mode uses its own command switch
// - not-separate mode switches reference and command together
module control_word_bit_router #(
   parameter NUM_BITS = `CWR_NUM_BITS,
   parameter NUM_TERM = `CWR_NUM_TERM
) (
   input wire clock,
   input wire rst_n,
   input wire [NUM_TERM-1:0] terminalInputs,
   input wire expansionFitted,
   input wire extendedFitted,
   input wire [NUM_BITS-1:0] modbusWord,
   input wire [NUM_BITS-1:0] canopenWord,
   input wire [NUM_BITS-1:0] netcardWord,
   input wire [NUM_BITS-1:0] internalCtrlWord,
   input wire runMode,
   input wire separateMode,
   input wire directReferenceSwitch,
   input wire commandChannelSwitch,
   input wire [2:0] commandChannel1Source,
   input wire [2:0] commandChannel2Source,
   input wire cfgWrite,
   input wire [3:0] cfgBit,
   input wire [1:0] cfgOp,
   input wire [2:0] cfgSource,
   input wire [3:0] cfgSwitchInput,
   input wire [3:0] readBit,
   output reg [NUM_BITS-1:0] functionBits_reg,
   output reg commandChannel2_reg,
   output reg cfgAccepted_reg,
   output reg cfgRejected_reg,
   output reg [1:0] readKind_reg,
   output reg [2:0] readSource_reg,
   output reg [3:0] readSwitch_reg
);

   // flattened views of the per-bit assignment table
   wire [2*NUM_BITS-1:0] kindFlat;
   wire [3*NUM_BITS-1:0] sourceFlat;
   wire [4*NUM_BITS-1:0] switchFlat;
   wire [NUM_BITS-1:0] routedBits;
   wire [NUM_BITS-1:0] termBits;
   wire [NUM_BITS-1:0] termValid;
   wire [NUM_BITS-1:0] switchLevels;

   reg [NUM_BITS-1:0] functionBits_next;
   reg commandChannel2_next;
   reg [2:0] activeSource;
   reg [1:0] targetKind;
   reg targetReserved;
   reg targetTermValid;
   reg switchInputOk;
   reg cfgLegal;
   reg forwardBit;
   reg authorizeBit;

   // fitted state of the terminal input at a given index
   function inputFitted;
      input [3:0] idx;
      input expFit;
      input extFit;
      begin
         if (idx < `CWR_EXP_FIRST) begin
            inputFitted = 1'b1;
         end else if (idx < `CWR_EXT_FIRST) begin
            inputFitted = expFit;
         end else if (idx < `CWR_NUM_TERM) begin
            inputFitted = extFit;
         end else begin
            inputFitted = 1'b0;
         end
      end
   endfunction

   // bit of the given command channel at the given position
   function channelBit;
      input [2:0] src;
      input [3:0] pos;
      input [NUM_TERM-1:0] term;
      input [NUM_BITS-1:0] mb;
      input [NUM_BITS-1:0] co;
      input [NUM_BITS-1:0] nc;
      input [NUM_BITS-1:0] ic;
      begin
         case (src)
            `CWR_SRC_TERMINAL: channelBit = term[pos];
            `CWR_SRC_MODBUS: channelBit = mb[pos];
            `CWR_SRC_CANOPEN: channelBit = co[pos];
            `CWR_SRC_NETCARD: channelBit = nc[pos];
            `CWR_SRC_INTERNAL: channelBit = ic[pos];
            default: channelBit = 1'b0;
         endcase
      end
   endfunction

   // per-bit table entry, terminal mapping and source selector
   genvar i;
   generate
      for (i = 0; i < NUM_BITS; i = i + 1) begin : gBit
         reg [1:0] kind_reg;
         reg [2:0] source_reg;
         reg [3:0] switch_reg;
         wire writeHere;
         localparam [3:0] BIT_INDEX = i;

         assign writeHere = cfgWrite & cfgLegal & (cfgBit == i);

         // table entry updates only on an accepted write to this bit
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               kind_reg <= `CWR_RST_KIND;
               source_reg <= `CWR_RST_SRC;
               switch_reg <= `CWR_RST_SWITCH;
            end else if (writeHere) begin
               case (cfgOp)
                  `CWR_OP_FIXED: begin
                     kind_reg <= `CWR_KIND_FIXED;
                     source_reg <= cfgSource;
                     switch_reg <= `CWR_RST_SWITCH;
                  end
                  `CWR_OP_SWITCHED: begin
                     kind_reg <= `CWR_KIND_SWITCHED;
                     source_reg <= cfgSource;
                     switch_reg <= cfgSwitchInput;
                  end
                  default: begin
                     kind_reg <= `CWR_KIND_NONE;
                     source_reg <= `CWR_RST_SRC;
                     switch_reg <= `CWR_RST_SWITCH;
                  end
               endcase
            end
         end

         assign kindFlat[2*i+1:2*i] = kind_reg;
         assign sourceFlat[3*i+2:3*i] = source_reg;
         assign switchFlat[4*i+3:4*i] = switch_reg;

         // terminal input of the same order, absent above the last input
         if (i < NUM_TERM) begin : gTerm
            assign termBits[i] = terminalInputs[i];
         end else begin : gNoTerm
            assign termBits[i] = 1'b0;
         end
         assign termValid[i] = inputFitted(BIT_INDEX, expansionFitted, extendedFitted);

         // level of the configured switch input, low when its card is absent
         assign switchLevels[i] = terminalInputs[switch_reg] &
            inputFitted(switch_reg, expansionFitted, extendedFitted);

         bit_source_select bit_source_select_inst (
            .kind(kind_reg),
            .source(source_reg),
            .switchLevel(switchLevels[i]),
            .terminalBit(termBits[i]),
            .terminalValid(termValid[i]),
            .modbusBit(modbusWord[i]),
            .canopenBit(canopenWord[i]),
            .netcardBit(netcardWord[i]),
            .internalBit(internalCtrlWord[i]),
            .value(routedBits[i])
         );
      end
   endgenerate

   // command channel selection follows the mode's switch signal
   always @* begin
      if (separateMode) begin
         commandChannel2_next = commandChannelSwitch;
      end else begin
         commandChannel2_next = directReferenceSwitch;
      end
   end

   // source of the active command channel, used by the locked run bits
   always @* begin
      if (commandChannel2_reg) begin
         activeSource = commandChannel2Source;
      end else begin
         activeSource = commandChannel1Source;
      end
   end

   // run command bits taken from the active command channel
   always @* begin
      forwardBit = 1'b0;
      authorizeBit = 1'b0;
      if (runMode == `CWR_MODE_THREE_WIRE) begin
         authorizeBit = channelBit(activeSource, 4'h0, terminalInputs, modbusWord,
            canopenWord, netcardWord, internalCtrlWord);
         forwardBit = channelBit(activeSource, 4'h1, terminalInputs, modbusWord,
            canopenWord, netcardWord, internalCtrlWord);
      end else begin
         forwardBit = channelBit(activeSource, 4'h0, terminalInputs, modbusWord,
            canopenWord, netcardWord, internalCtrlWord);
      end
   end

   // routed bits with the run bits locked according to the command mode
   always @* begin
      functionBits_next = routedBits;
      if (runMode == `CWR_MODE_THREE_WIRE) begin
         functionBits_next[0] = authorizeBit;
         functionBits_next[1] = forwardBit;
      end else begin
         functionBits_next[0] = forwardBit;
      end
   end

   // facts about the bit addressed by a configuration write
   always @* begin
      targetKind = kindFlat[2*cfgBit +: 2];
      targetTermValid = inputFitted(cfgBit, expansionFitted, extendedFitted);
      switchInputOk = inputFitted(cfgSwitchInput, expansionFitted, extendedFitted);
      if (runMode == `CWR_MODE_THREE_WIRE) begin
         targetReserved = (cfgBit <= 4'h1);
      end else begin
         targetReserved = (cfgBit == 4'h0);
      end
   end

   // legality check of a configuration write
   always @* begin
      cfgLegal = 1'b0;
      if (!targetReserved) begin
         case (cfgOp)
            `CWR_OP_CLEAR: cfgLegal = 1'b1;
            `CWR_OP_FIXED: begin
               // a switched bit refuses a fixed assignment
               if (targetKind == `CWR_KIND_SWITCHED) begin
                  cfgLegal = 1'b0;
               end else if (cfgSource == `CWR_SRC_TERMINAL) begin
                  cfgLegal = targetTermValid;
               end else begin
                  cfgLegal = (cfgSource <= `CWR_SRC_INTERNAL);
               end
            end
            `CWR_OP_SWITCHED: begin
               // a fixed bit refuses a switched assignment
               if (targetKind == `CWR_KIND_FIXED) begin
                  cfgLegal = 1'b0;
               end else begin
                  cfgLegal = (cfgSource != `CWR_SRC_TERMINAL) &&
                     (cfgSource <= `CWR_SRC_INTERNAL) && switchInputOk;
               end
            end
            default: cfgLegal = 1'b0;
         endcase
      end
   end

   // output bits and command channel, all taking effect on the next edge
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         functionBits_reg <= `CWR_RST_BITS;
         commandChannel2_reg <= 1'b0;
      end else begin
         functionBits_reg <= functionBits_next;
         commandChannel2_reg <= commandChannel2_next;
      end
   end

   // one-cycle answer to each configuration write
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfgAccepted_reg <= 1'b0;
         cfgRejected_reg <= 1'b0;
      end else begin
         cfgAccepted_reg <= cfgWrite & cfgLegal;
         cfgRejected_reg <= cfgWrite & ~cfgLegal;
      end
   end

   // readback of the table entry of the selected bit
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         readKind_reg <= `CWR_RST_KIND;
         readSource_reg <= `CWR_RST_SRC;
         readSwitch_reg <= `CWR_RST_SWITCH;
      end else begin
         readKind_reg <= kindFlat[2*readBit +: 2];
         readSource_reg <= sourceFlat[3*readBit +: 3];
         readSwitch_reg <= switchFlat[4*readBit +: 4];
      end
   end

endmodule

// ===== tb/source_model.sv
// far-side sources: terminal inputs and four fieldbus control words
// assumes the bench moves seed just after a rising clock edge
`timescale 1ns/1ps
module source_model (
   input wire logic [15:0] seed,
   output wire logic [13:0] terminalInputs,
   output wire logic [15:0] modbusWord,
   output wire logic [15:0] canopenWord,
   output wire logic [15:0] netcardWord,
   output wire logic [15:0] internalCtrlWord
);
   // the four words show distinct patterns; terminal inputs repeat modbus bits 0-13
   assign terminalInputs = seed[13:0];
   assign modbusWord = seed;
   assign canopenWord = ~seed; // always differs from modbus at every position
   assign netcardWord = {seed[7:0], seed[15:8]};
   assign internalCtrlWord = seed ^ 16'h5a5a;
endmodule

// ===== tb/control_word_bit_router_properties.sv
// checker of the router's configuration answers and command channel choice
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module control_word_bit_router_properties (
   input wire clock,
   input wire rst_n,
   input wire runMode,
   input wire separateMode,
   input wire directReferenceSwitch,
   input wire commandChannelSwitch,
   input wire cfgWrite,
   input wire [3:0] cfgBit,
   input wire [1:0] cfgOp,
   input wire [2:0] cfgSource,
   input wire commandChannel2_reg,
   input wire cfgAccepted_reg,
   input wire cfgRejected_reg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // every write gets exactly one answer, one cycle later
   AST_ONE_ANSWER: assert property (cfgWrite |=> cfgAccepted_reg != cfgRejected_reg)
      else $error("config write without a single answer");
   AST_NO_SPURIOUS: assert property (!cfgWrite |=> !cfgAccepted_reg && !cfgRejected_reg)
      else $error("answer without a config write");
   AST_ILLEGAL_OP: assert property (cfgWrite && cfgOp == 2'h3 |=> cfgRejected_reg)
      else $error("illegal op accepted");
   AST_TWO_WIRE_LOCK: assert property (cfgWrite && !runMode && cfgBit == 4'h0 |=> cfgRejected_reg)
      else $error("locked bit 0 accepted in two-wire mode");
   AST_THREE_WIRE_LOCK: assert property (cfgWrite && runMode && cfgBit < 4'h2 |=> cfgRejected_reg)
      else $error("locked bit accepted in three-wire mode");
   AST_NO_TERMINAL_HIGH: assert property (cfgWrite && cfgOp == 2'h1 && cfgSource == 3'h0 && cfgBit > 4'hd
      |=> cfgRejected_reg)
      else $error("terminal source accepted on bit 14 or 15");
   AST_SWITCH_NEEDS_WORD: assert property (cfgWrite && cfgOp == 2'h2 && cfgSource == 3'h0
      |=> cfgRejected_reg)
      else $error("switched assignment accepted with terminal word");
   AST_SEPARATE_SWITCH: assert property (separateMode
      |=> commandChannel2_reg == $past(commandChannelSwitch))
      else $error("separate mode channel not from command switch");
   AST_SLAVED_SWITCH: assert property (!separateMode
      |=> commandChannel2_reg == $past(directReferenceSwitch))
      else $error("not-separate channel not from reference switch");
   // main scenarios reached
   COV_SWITCHED: cover property (cfgWrite && cfgOp == 2'h2 ##1 cfgAccepted_reg);
   COV_SEPARATE: cover property (separateMode && commandChannel2_reg);
   COV_LOCK: cover property (runMode && cfgRejected_reg);
endmodule
bind control_word_bit_router control_word_bit_router_properties control_word_bit_router_properties_inst (
   .clock, .rst_n, .runMode, .separateMode, .directReferenceSwitch, .commandChannelSwitch, .cfgWrite,
   .cfgBit, .cfgOp, .cfgSource, .commandChannel2_reg, .cfgAccepted_reg, .cfgRejected_reg);

// ===== tb/control_word_bit_router_bench.sv
// self-checking bench of the control word bit router
// assumes the source model drives terminal inputs and control words
`timescale 1ns/1ps
module control_word_bit_router_bench;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [15:0] seed = 16'h0000;
   logic expansionFitted = 1'h0, extendedFitted = 1'h1, runMode = 1'h0, separateMode = 1'h0;
   logic directReferenceSwitch = 1'h0, commandChannelSwitch = 1'h0, cfgWrite = 1'h0;
   logic [2:0] commandChannel1Source = 3'h1, commandChannel2Source = 3'h2, cfgSource = 3'h0;
   logic [3:0] cfgBit = 4'h0, cfgSwitchInput = 4'h0, readBit = 4'h0;
   logic [1:0] cfgOp = 2'h0;
   wire [13:0] terminalInputs;
   wire [15:0] modbusWord, canopenWord, netcardWord, internalCtrlWord, functionBits_reg;
   wire commandChannel2_reg, cfgAccepted_reg, cfgRejected_reg;
   wire [1:0] readKind_reg;
   wire [2:0] readSource_reg;
   wire [3:0] readSwitch_reg;
   int error_cnt = 0, check_count = 0, cycles = 0;
   source_model source_model_inst (.seed(seed), .terminalInputs(terminalInputs), .modbusWord(modbusWord),
      .canopenWord(canopenWord), .netcardWord(netcardWord), .internalCtrlWord(internalCtrlWord));
   control_word_bit_router control_word_bit_router_inst (.clock(clock), .rst_n(rst_n),
      .terminalInputs(terminalInputs), .expansionFitted(expansionFitted), .extendedFitted(extendedFitted),
      .modbusWord(modbusWord), .canopenWord(canopenWord), .netcardWord(netcardWord),
      .internalCtrlWord(internalCtrlWord), .runMode(runMode), .separateMode(separateMode),
      .directReferenceSwitch(directReferenceSwitch), .commandChannelSwitch(commandChannelSwitch),
      .commandChannel1Source(commandChannel1Source), .commandChannel2Source(commandChannel2Source),
      .cfgWrite(cfgWrite), .cfgBit(cfgBit), .cfgOp(cfgOp), .cfgSource(cfgSource),
      .cfgSwitchInput(cfgSwitchInput), .readBit(readBit), .functionBits_reg(functionBits_reg),
      .commandChannel2_reg(commandChannel2_reg), .cfgAccepted_reg(cfgAccepted_reg),
      .cfgRejected_reg(cfgRejected_reg), .readKind_reg(readKind_reg), .readSource_reg(readSource_reg),
      .readSwitch_reg(readSwitch_reg));
   // 200 MHz clock
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] expv, input logic [15:0] seen);
      check_count++;
      if (seen !== expv) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, expv, seen);
      end
   endtask
   // one write pulse, answer judged in the cycle after it is taken
   task automatic cfg(input logic [3:0] b, input logic [1:0] op, input logic [2:0] src, input logic [3:0] sw,
      input logic acc);
      @(posedge clock);
      cfgWrite <= 1'h1;
      cfgBit <= b;
      cfgOp <= op;
      cfgSource <= src;
      cfgSwitchInput <= sw;
      @(posedge clock);
      cfgWrite <= 1'h0;
      #1;
      chk("cfg accepted", 16'(acc), 16'(cfgAccepted_reg));
      chk("cfg rejected", 16'(!acc), 16'(cfgRejected_reg));
   endtask
   // lets routing and the two-cycle locked-bit lag land
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic t_reset();
      #1;
      chk("bits after reset", 16'h0000, functionBits_reg);
   endtask
   task automatic t_fixed();
      logic [15:0] e;
      cfg(4'h4, 2'h1, 3'h0, 4'h0, 1'h1);
      cfg(4'h7, 2'h1, 3'h0, 4'h0, 1'h0);
      @(posedge clock);
      expansionFitted <= 1'h1;
      cfg(4'h7, 2'h1, 3'h0, 4'h0, 1'h1);
      cfg(4'hb, 2'h1, 3'h0, 4'h0, 1'h1);
      cfg(4'he, 2'h1, 3'h0, 4'h0, 1'h0);
      cfg(4'h2, 2'h1, 3'h1, 4'h0, 1'h1);
      cfg(4'h3, 2'h1, 3'h2, 4'h0, 1'h1);
      cfg(4'h5, 2'h1, 3'h3, 4'h0, 1'h1);
      cfg(4'h6, 2'h1, 3'h4, 4'h0, 1'h1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         seed <= (i == 0) ? 16'h2c5a : 16'hd3a5;
         settle();
         e = 16'h0000;
         e[2] = modbusWord[2];
         e[3] = canopenWord[3];
         e[4] = terminalInputs[4];
         e[5] = netcardWord[5];
         e[6] = internalCtrlWord[6];
         e[7] = terminalInputs[7];
         e[11] = terminalInputs[11];
         chk("fixed bits", e, functionBits_reg & 16'h88fc);
      end
   endtask
   task automatic t_switched();
      cfg(4'hc, 2'h2, 3'h2, 4'h1, 1'h1);
      cfg(4'hc, 2'h1, 3'h1, 4'h0, 1'h0);
      cfg(4'h4, 2'h2, 3'h1, 4'h1, 1'h0);
      cfg(4'hd, 2'h2, 3'h0, 4'h1, 1'h0);
      cfg(4'h9, 2'h3, 3'h1, 4'h0, 1'h0);
      cfg(4'h9, 2'h1, 3'h5, 4'h0, 1'h0);
      cfg(4'h9, 2'h2, 3'h3, 4'he, 1'h0);
      cfg(4'he, 2'h2, 3'h4, 4'h1, 1'h1);
      @(posedge clock);
      readBit <= 4'hc;
      seed <= 16'h1002;
      settle();
      chk("read kind", 16'h0002, 16'(readKind_reg));
      chk("read source", 16'h0002, 16'(readSource_reg));
      chk("read switch", 16'h0001, 16'(readSwitch_reg));
      chk("switched to word", 16'(canopenWord[12]), 16'(functionBits_reg[12]));
      chk("switched bit14 to word", 16'(internalCtrlWord[14]), 16'(functionBits_reg[14]));
      @(posedge clock);
      seed <= 16'h1000;
      settle();
      chk("switched to terminal", 16'(terminalInputs[12]), 16'(functionBits_reg[12]));
      chk("switched bit14 no terminal", 16'h0000, 16'(functionBits_reg[14]));
   endtask
   task automatic t_run();
      @(posedge clock);
      seed <= 16'h0001;
      settle();
      chk("two-wire ch1 bit0", 16'(modbusWord[0]), 16'(functionBits_reg[0]));
      cfg(4'h0, 2'h1, 3'h1, 4'h0, 1'h0);
      @(posedge clock);
      directReferenceSwitch <= 1'h1;
      settle();
      chk("slaved channel", 16'h0001, 16'(commandChannel2_reg));
      chk("two-wire ch2 bit0", 16'(canopenWord[0]), 16'(functionBits_reg[0]));
      @(posedge clock);
      separateMode <= 1'h1;
      settle();
      chk("separate ch1 bit0", 16'(modbusWord[0]), 16'(functionBits_reg[0]));
      @(posedge clock);
      runMode <= 1'h1;
      commandChannelSwitch <= 1'h1;
      seed <= 16'h0002;
      settle();
      chk("three-wire run bits", 16'(canopenWord[1:0]), 16'(functionBits_reg[1:0]));
      cfg(4'h1, 2'h1, 3'h1, 4'h0, 1'h0);
      cfg(4'h2, 2'h0, 3'h0, 4'h0, 1'h1);
      // mid-run reset must clear routed bits and the assignment table
      @(posedge clock);
      rst_n <= 1'h0;
      @(posedge clock);
      #1;
      chk("bits in reset", 16'h0000, functionBits_reg);
      chk("read kind in reset", 16'h0000, 16'(readKind_reg));
      @(posedge clock);
      rst_n <= 1'h1;
      settle();
      chk("table cleared by reset", 16'h0000, 16'(readKind_reg));
   endtask
   // hang guard
   initial begin
      forever begin
         @(posedge clock);
         cycles++;
         if (cycles == 4000) begin
            error_cnt++;
            final_report();
         end
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'h1;
      t_reset();
      t_fixed();
      t_switched();
      t_run();
      final_report();
   end
endmodule
